// file: src/ctb_device.sv
/*
  Controller end: three transmit buffers, local priority contest, abort
  handshake, time stamp timer and capture.
  Assumes a protocol engine beside it giving start-of-frame, ack and error pulses
  on the same clock, and a software end on the ctb_if dev modport.
*/
`include "ctb_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ctb_device
  import ctb_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  ctb_if.dev bus,
  input wire logic i_sof_pulse,
  input wire logic i_tx_ack,
  input wire logic i_tx_err,
  input wire logic i_rx_ack,
  input wire logic i_bit_tick,
  output logic o_tx_pending,
  output logic o_tx_start,
  output logic o_tx_busy,
  output logic [1:0] o_tx_buf,
  output logic [31:0] o_tx_id,
  output logic [63:0] o_tx_data,
  output logic [3:0] o_tx_len,
  output logic [`CTB_STAMP_W-1:0] o_rx_stamp
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  ctb_byte_t mem_q [`CTB_NBUF][`CTB_WIN_BYTES];
  ctb_bufmask_t empty_q, empty_d;
  ctb_bufmask_t ack_q, ack_d;
  ctb_bufmask_t arq_q, arq_d;
  ctb_bufmask_t sel_q;
  logic busy_q;
  logic [1:0] act_q;
  logic start_q;
  logic irq_q;
  logic [`CTB_STAMP_W-1:0] timer_q;
  logic [`CTB_STAMP_W-1:0] rx_stamp_q;
  ctb_byte_t rdata_q;
  logic [31:0] id_q;
  logic [63:0] data_q;
  logic [3:0] len_q;

  // ----------------------------------------
  // Window decode
  // ----------------------------------------
  wire sel_hit = |sel_q;
  wire [1:0] sel_idx = sel_q[0] ? 2'h0 : (sel_q[1] ? 2'h1 : 2'h2);
  wire win_open = sel_hit & empty_q[sel_idx];
  wire win_wr = bus.win_we & win_open & (bus.win_addr < `CTB_WIN_TSH);
  wire win_rd = bus.win_re & win_open;

  // ----------------------------------------
  // Local priority contest
  // ----------------------------------------
  wire ctb_bufmask_t elig = ~empty_q & ~ack_q;
  logic [1:0] win_idx;
  logic win_found;
  always_comb begin
    win_idx = 2'h0;
    win_found = 1'b0;
    for (int i = 0; i < `CTB_NBUF; i++) begin
      // Strict compare keeps the lower index on ties
      if (elig[i] && (!win_found || (mem_q[i][`CTB_WIN_LOCAL_PRIORITY_FIELD] < mem_q[win_idx][`CTB_WIN_LOCAL_PRIORITY_FIELD]))) begin
        win_idx = 2'(i);
        win_found = 1'b1;
      end
    end
  end
  wire grant = i_sof_pulse & ~busy_q & win_found;
  wire done_ok = busy_q & i_tx_ack;
  wire done_err = busy_q & i_tx_err;

  // Payload of winner, bytes beyond the length code zeroed
  wire [3:0] win_len_raw = mem_q[win_idx][`CTB_WIN_LEN][3:0];
  wire [3:0] win_len = (win_len_raw > `CTB_MAX_BYTES) ? `CTB_MAX_BYTES : win_len_raw;
  logic [63:0] win_data;
  always_comb begin
    win_data = 64'h0;
    for (int b = 0; b < 8; b++) begin
      if (4'(b) < win_len) begin
        win_data[63-8*b -: 8] = mem_q[win_idx][`CTB_WIN_DATA0 + 4'(b)];
      end
    end
  end

  // ----------------------------------------
  // Flag next state
  // ----------------------------------------
  always_comb begin
    empty_d = empty_q;
    ack_d = ack_q;
    arq_d = arq_q;
    for (int i = 0; i < `CTB_NBUF; i++) begin
      if (bus.flag_we && bus.flag_wdata[i] && empty_q[i]) begin
        empty_d[i] = 1'b0;
        ack_d[i] = 1'b0;
      end
      if (bus.arq_we && bus.arq_wdata[i] && !empty_q[i]) begin
        arq_d[i] = 1'b1;
      end
      // Active frame is never aborted
      if (arq_q[i] && !empty_q[i] && !ack_q[i] && !(busy_q && act_q == 2'(i)) &&
          !(grant && win_idx == 2'(i))) begin
        ack_d[i] = 1'b1;
      end
      // Acknowledge lands first, buffer released one cycle later
      if (ack_q[i] && !empty_q[i]) begin
        empty_d[i] = 1'b1;
        arq_d[i] = 1'b0;
      end
      if (done_ok && act_q == 2'(i)) begin
        empty_d[i] = 1'b1;
        ack_d[i] = 1'b0;
        arq_d[i] = 1'b0;
      end
    end
  end
  wire ctb_bufmask_t empty_rise = empty_d & ~empty_q;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      empty_q <= `CTB_EMPTY_RST;
      ack_q <= '0;
      arq_q <= '0;
      sel_q <= '0;
      irq_q <= 1'b0;
    end else begin
      empty_q <= empty_d;
      ack_q <= ack_d;
      arq_q <= arq_d;
      irq_q <= |(empty_rise & bus.irq_mask);
      if (bus.sel_we) begin
        sel_q <= bus.sel_wdata;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_q <= 1'b0;
      act_q <= 2'h0;
      start_q <= 1'b0;
    end else begin
      start_q <= grant;
      if (grant) begin
        busy_q <= 1'b1;
        act_q <= win_idx;
      end else if (done_ok || done_err) begin
        busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      id_q <= '0;
      data_q <= '0;
      len_q <= '0;
    end else if (grant) begin
      id_q <= {mem_q[win_idx][0], mem_q[win_idx][1], mem_q[win_idx][2], mem_q[win_idx][3]};
      data_q <= win_data;
      len_q <= win_len;
    end
  end

  // ----------------------------------------
  // Stamp timer
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      timer_q <= '0;
      rx_stamp_q <= '0;
    end else begin
      if (bus.init_mode) begin
        timer_q <= '0;
      end else if (i_bit_tick) begin
        timer_q <= timer_q + 16'h0001;
      end
      if (i_rx_ack && bus.stamp_en) begin
        rx_stamp_q <= timer_q;
      end
    end
  end

  // ----------------------------------------
  // Buffer memory and window read
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < `CTB_NBUF; i++) begin
        for (int j = 0; j < `CTB_WIN_BYTES; j++) begin
          mem_q[i][j] <= 8'h00;
        end
      end
    end else begin
      if (win_wr) begin
        mem_q[sel_idx][bus.win_addr] <= bus.win_wdata;
      end
      if (done_ok && bus.stamp_en) begin
        mem_q[act_q][`CTB_WIN_TSH] <= timer_q[15:8];
        mem_q[act_q][`CTB_WIN_TSL] <= timer_q[7:0];
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= win_rd ? mem_q[sel_idx][bus.win_addr] : 8'h00;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus.win_rdata = rdata_q;
  assign bus.empty_flags = empty_q;
  assign bus.abort_acks = ack_q;
  assign bus.tx_irq = irq_q;
  assign o_tx_pending = |elig;
  assign o_tx_start = start_q;
  assign o_tx_busy = busy_q;
  assign o_tx_buf = act_q;
  assign o_tx_id = id_q;
  assign o_tx_data = data_q;
  assign o_tx_len = len_q;
  assign o_rx_stamp = rx_stamp_q;

endmodule
`default_nettype wire

// file: src/ctb_params.svh
/*
  Constants for the transmit buffer scheduler: window offsets, counts, reset values.
  Assumes inclusion by both ends and the interface.
*/
`ifndef CTB_PARAMS_SVH
`define CTB_PARAMS_SVH

// ----------------------------------------
// Buffer organisation
// ----------------------------------------
`define CTB_NBUF 3
`define CTB_WIN_BYTES 16
`define CTB_EMPTY_RST 3'h7
`define CTB_STAMP_W 16

// ----------------------------------------
// Foreground window byte offsets
// ----------------------------------------
`define CTB_WIN_ID0 4'h0
`define CTB_WIN_DATA0 4'h4
`define CTB_WIN_LEN 4'hC
`define CTB_WIN_LOCAL_PRIORITY_FIELD 4'hD
`define CTB_WIN_TSH 4'hE
`define CTB_WIN_TSL 4'hF

// ----------------------------------------
// Length code and host loading
// ----------------------------------------
`define CTB_MAX_BYTES 4'h8
`define CTB_LOAD_LAST 4'hD
`define CTB_FIFO_DEPTH 8
`define CTB_FIFO_W 108

`endif

// file: src/ctb_pkg.sv
/*
  Types shared by both ends of the transmit buffer scheduler.
  Assumes ctb_params.svh is on the include path.
*/
`include "ctb_params.svh"
package ctb_pkg;
  typedef logic [7:0] ctb_byte_t;
  typedef logic [`CTB_NBUF-1:0] ctb_bufmask_t;
  typedef enum logic [3:0] {
    CTB_H_IDLE = 4'h1,
    CTB_H_SEL = 4'h2,
    CTB_H_LOAD = 4'h4,
    CTB_H_ARM = 4'h8
  } ctb_hstate_t;
endpackage

// file: src/ctb_if.sv
/*
  Register-side carrier between the controller's buffers and the software end.
  Assumes both ends share one clock; no tristate.
*/
`include "ctb_params.svh"
`timescale 1ns/1ps
`default_nettype none
interface ctb_if;
  import ctb_pkg::*;
  logic sel_we;
  ctb_bufmask_t sel_wdata;
  logic win_we;
  logic win_re;
  logic [3:0] win_addr;
  ctb_byte_t win_wdata;
  ctb_byte_t win_rdata;
  logic flag_we;
  ctb_bufmask_t flag_wdata;
  ctb_bufmask_t empty_flags;
  logic arq_we;
  ctb_bufmask_t arq_wdata;
  ctb_bufmask_t abort_acks;
  logic stamp_en;
  logic init_mode;
  ctb_bufmask_t irq_mask;
  logic tx_irq;
  modport dev (
    input sel_we, sel_wdata, win_we, win_re, win_addr, win_wdata, flag_we, flag_wdata,
    input arq_we, arq_wdata, stamp_en, init_mode, irq_mask,
    output win_rdata, empty_flags, abort_acks, tx_irq
  );
  modport host (
    output sel_we, sel_wdata, win_we, win_re, win_addr, win_wdata, flag_we, flag_wdata,
    output arq_we, arq_wdata, stamp_en, init_mode, irq_mask,
    input win_rdata, empty_flags, abort_acks, tx_irq
  );
endinterface
`default_nettype wire

// file: src/ctb_host.sv
/*
  Software end: a message FIFO and a loader that selects an empty buffer,
  fills the window, then arms it; abort and mode controls pass through.
  Assumes the controller end on the ctb_if host modport, same clock.
*/
`include "ctb_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ctb_fifo
  import ctb_pkg::*;
#(
  parameter int WIDTH = `CTB_FIFO_W,
  parameter int DEPTH = `CTB_FIFO_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty = (wr_q == rd_q);
  wire push = i_valid & ~full;
  wire pop = i_ready & ~empty;
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= i_data;
    end
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end
  assign o_ready = ~full;
  assign o_valid = ~empty;
  assign o_data = mem[rd_q[AW-1:0]];
endmodule

module ctb_host
  import ctb_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  ctb_if.host bus,
  input wire logic i_msg_valid,
  output logic o_msg_ready,
  input wire logic [31:0] i_msg_id,
  input wire logic [63:0] i_msg_data,
  input wire logic [3:0] i_msg_len,
  input wire logic [7:0] i_msg_local_priority_field,
  input wire logic [2:0] i_abort_req,
  input wire logic i_stamp_en,
  input wire logic i_init_mode,
  input wire logic [2:0] i_irq_mask,
  output logic [2:0] o_buf_empty,
  output logic [2:0] o_buf_aborted,
  output logic o_tx_irq
);

  // ----------------------------------------
  // Message queue
  // ----------------------------------------
  logic q_valid;
  logic q_pop;
  logic [`CTB_FIFO_W-1:0] q_data;
  ctb_fifo #(.WIDTH(`CTB_FIFO_W), .DEPTH(`CTB_FIFO_DEPTH)) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_valid(i_msg_valid),
    .o_ready(o_msg_ready),
    .i_data({i_msg_id, i_msg_data, i_msg_len, i_msg_local_priority_field}),
    .o_valid(q_valid),
    .i_ready(q_pop),
    .o_data(q_data)
  );

  // ----------------------------------------
  // Loader state
  // ----------------------------------------
  ctb_hstate_t state_q, state_d;
  ctb_bufmask_t tgt_q;
  logic [3:0] cnt_q;
  wire ctb_bufmask_t free = bus.empty_flags;
  wire ctb_bufmask_t pick = free[0] ? 3'h1 : (free[1] ? 3'h2 : 3'h4);
  wire load_last = (cnt_q == `CTB_LOAD_LAST);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CTB_H_IDLE: if (q_valid && |free) state_d = CTB_H_SEL;
      CTB_H_SEL: state_d = CTB_H_LOAD;
      CTB_H_LOAD: if (load_last) state_d = CTB_H_ARM;
      CTB_H_ARM: state_d = CTB_H_IDLE;
      default: state_d = CTB_H_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= CTB_H_IDLE;
      tgt_q <= '0;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == CTB_H_IDLE) begin
        tgt_q <= pick;
      end
      cnt_q <= (state_q == CTB_H_LOAD) ? cnt_q + 4'h1 : 4'h0;
    end
  end

  // Byte for window offset cnt_q: id, data, length, priority
  wire [31:0] q_id = q_data[107:76];
  wire [63:0] q_pay = q_data[75:12];
  logic [7:0] load_byte;
  always_comb begin
    if (cnt_q < `CTB_WIN_DATA0) begin
      load_byte = q_id[31-8*cnt_q -: 8];
    end else if (cnt_q < `CTB_WIN_LEN) begin
      load_byte = q_pay[63-8*(cnt_q-`CTB_WIN_DATA0) -: 8];
    end else if (cnt_q == `CTB_WIN_LEN) begin
      load_byte = {4'h0, q_data[11:8]};
    end else begin
      load_byte = q_data[7:0];
    end
  end

  // ----------------------------------------
  // Bus drive
  // ----------------------------------------
  assign bus.sel_we = (state_q == CTB_H_SEL);
  assign bus.sel_wdata = tgt_q;
  assign bus.win_we = (state_q == CTB_H_LOAD);
  assign bus.win_re = 1'b0;
  assign bus.win_addr = cnt_q;
  assign bus.win_wdata = load_byte;
  assign bus.flag_we = (state_q == CTB_H_ARM);
  assign bus.flag_wdata = tgt_q;
  assign q_pop = (state_q == CTB_H_ARM);
  assign bus.arq_we = |i_abort_req;
  assign bus.arq_wdata = i_abort_req;
  assign bus.stamp_en = i_stamp_en;
  assign bus.init_mode = i_init_mode;
  assign bus.irq_mask = i_irq_mask;
  assign o_buf_empty = bus.empty_flags;
  assign o_buf_aborted = bus.abort_acks;
  assign o_tx_irq = bus.tx_irq;

endmodule
`default_nettype wire

// file: bench/ctb_monitor.sv
/*
  Checker on the carrier: arming, abort order and interrupt timing.
  Assumes one clock; placed beside the carrier by the bench.
*/
`include "ctb_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ctb_monitor
  import ctb_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic sel_we,
  input wire ctb_bufmask_t sel_wdata,
  input wire logic win_we,
  input wire logic [3:0] win_addr,
  input wire logic flag_we,
  input wire ctb_bufmask_t flag_wdata,
  input wire ctb_bufmask_t empty_flags,
  input wire ctb_bufmask_t abort_acks,
  input wire ctb_bufmask_t irq_mask,
  input wire logic tx_irq
);
  // ------------------
  // Helper state
  // ------------------
  ctb_bufmask_t prev_q;
  ctb_bufmask_t ack_q;
  ctb_bufmask_t rise;
  ctb_bufmask_t new_ack;
  assign rise = empty_flags & ~prev_q;
  assign new_ack = abort_acks & ~ack_q;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_q <= `CTB_EMPTY_RST;
      ack_q <= '0;
    end else begin
      prev_q <= empty_flags;
      ack_q <= abort_acks;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // ------------------
  // Assertions
  // ------------------
  a_arm_clears_flags: assert property (
    (flag_we && (flag_wdata & empty_flags) != '0) |=> ((empty_flags | abort_acks) & $past(flag_wdata & empty_flags)) == '0)
    else $error("arming left a flag set");
  a_empty_falls_armed: assert property (
    (($past(empty_flags) & ~empty_flags) != '0) |-> $past(flag_we))
    else $error("empty flag fell without an arm write");
  a_sel_one_empty: assert property (
    sel_we |-> ($onehot(sel_wdata) && (sel_wdata & ~empty_flags) == '0))
    else $error("select of a busy buffer");
  a_win_no_stamp: assert property (
    win_we |-> (win_addr < `CTB_WIN_TSH))
    else $error("window write to a stamp byte");
  a_arm_after_load: assert property (
    flag_we |-> ($past(win_we) && $past(win_addr) == `CTB_WIN_LOCAL_PRIORITY_FIELD))
    else $error("buffer armed before loading ended");
  a_irq_per_rise: assert property (
    tx_irq == ((rise & $past(irq_mask)) != '0))
    else $error("interrupt does not match an unmasked release");
  a_abort_ack_first: assert property (
    (new_ack != '0) |-> ((empty_flags & new_ack) == '0) ##1 ((empty_flags & $past(new_ack)) == $past(new_ack)))
    else $error("abort release out of order");
  a_ack_on_release: assert property (
    (rise != '0) |-> ((abort_acks & rise) == ($past(new_ack) & rise)))
    else $error("acknowledge wrong at release");
  c_abort: cover property (new_ack != '0);
  c_irq: cover property (tx_irq);
  c_arm: cover property (flag_we);
endmodule
`default_nettype wire

// file: bench/tb_top.sv
/*
  Bench: both ends joined by the carrier; engine pulses and user side driven here.
  Assumes design files and monitor compiled first.
*/
`include "ctb_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ctb_pkg::*;
;
  // ------------------
  // Signals
  // ------------------
  logic i_ref_clk, i_rst, msg_valid, stamp_en, init_mode, sof, tx_ack, tx_err, rx_ack, bit_tick;
  logic msg_ready, host_irq, tx_pending, tx_start, tx_busy;
  logic [31:0] msg_id, tx_id;
  logic [63:0] msg_data, tx_data;
  logic [3:0] msg_len, tx_len;
  logic [7:0] msg_local_priority_field;
  logic [1:0] tx_buf;
  logic [15:0] rx_stamp;
  ctb_bufmask_t abort_req, irq_mask, buf_empty, buf_aborted;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  int irqs, acc, w;
  bit ok;
  localparam logic [63:0] PAY = 64'h1122334455667788;
  ctb_if bus_if ();
  ctb_device u_ctb_device (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .bus(bus_if), .i_sof_pulse(sof),
    .i_tx_ack(tx_ack), .i_tx_err(tx_err), .i_rx_ack(rx_ack), .i_bit_tick(bit_tick), .o_tx_pending(tx_pending),
    .o_tx_start(tx_start), .o_tx_busy(tx_busy), .o_tx_buf(tx_buf), .o_tx_id(tx_id), .o_tx_data(tx_data),
    .o_tx_len(tx_len), .o_rx_stamp(rx_stamp));
  ctb_host u_ctb_host (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .bus(bus_if), .i_msg_valid(msg_valid),
    .o_msg_ready(msg_ready), .i_msg_id(msg_id), .i_msg_data(msg_data), .i_msg_len(msg_len), .i_msg_local_priority_field(msg_local_priority_field),
    .i_abort_req(abort_req), .i_stamp_en(stamp_en), .i_init_mode(init_mode), .i_irq_mask(irq_mask),
    .o_buf_empty(buf_empty), .o_buf_aborted(buf_aborted), .o_tx_irq(host_irq));
  ctb_monitor u_ctb_monitor (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .sel_we(bus_if.sel_we),
    .sel_wdata(bus_if.sel_wdata), .win_we(bus_if.win_we), .win_addr(bus_if.win_addr), .flag_we(bus_if.flag_we),
    .flag_wdata(bus_if.flag_wdata), .empty_flags(bus_if.empty_flags), .abort_acks(bus_if.abort_acks),
    .irq_mask(bus_if.irq_mask), .tx_irq(bus_if.tx_irq));
  // ------------------
  // Tasks
  // ------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    tick(1);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic send(input logic [31:0] id, input logic [3:0] len, input logic [7:0] pr, output bit acc_ok);
    tick(1);
    w = 0;
    while (msg_ready !== 1'b1 && w < 100) begin
      tick(1);
      w++;
    end
    acc_ok = (msg_ready === 1'b1);
    if (acc_ok) begin
      msg_id = id;
      msg_len = len;
      msg_local_priority_field = pr;
      msg_valid = 1'b1;
      tick(1);
      msg_valid = 1'b0;
    end
  endtask
  task automatic arb(input logic [31:0] id, input logic [3:0] len, input logic [63:0] d);
    pulse(sof);
    check(tx_start, 1'b1);
    check(tx_id, id);
    check(tx_len, len);
    check(tx_data, d);
  endtask
  task automatic watch();
    irqs = 0;
    repeat (6) begin
      if (host_irq === 1'b1) irqs++;
      tick(1);
    end
  endtask
  task automatic sent(input ctb_bufmask_t mask);
    irq_mask = mask;
    pulse(tx_ack);
    watch();
  endtask
  task automatic wait_empty(input ctb_bufmask_t e);
    w = 0;
    while (buf_empty !== e && w < 300) begin
      tick(1);
      w++;
    end
    check(buf_empty, e);
  endtask
  // ------------------
  // Clock, timeout, sequence
  // ------------------
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("wrong value at %0t: run timed out", $time);
      complete_run();
    end
  end
  initial begin
    i_rst = 1'b1;
    {msg_valid, stamp_en, init_mode, sof, tx_ack, tx_err, rx_ack, bit_tick} = 8'h00;
    msg_id = 32'h0;
    msg_data = PAY;
    msg_len = 4'h0;
    msg_local_priority_field = 8'h00;
    abort_req = 3'h0;
    irq_mask = 3'h7;
    repeat (8) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    check(buf_empty, `CTB_EMPTY_RST);
    check(buf_aborted, 3'h0);
    check(tx_busy, 1'b0);
    check(msg_ready, 1'b1);
    $display("test reset done");
    send(32'h000000A1, 4'h3, 8'h05, ok);
    send(32'h000000B2, 4'hC, 8'h02, ok);
    send(32'h000000C3, 4'h8, 8'h02, ok);
    wait_empty(3'h0);
    arb(32'h000000B2, 4'h8, PAY);
    pulse(tx_err);
    check(tx_busy, 1'b0);
    arb(32'h000000B2, 4'h8, PAY);
    check(tx_buf, 2'h1);
    sent(3'h7);
    check(irqs, 1);
    check(buf_empty, 3'h2);
    arb(32'h000000C3, 4'h8, PAY);
    sent(3'h0);
    check(irqs, 0);
    check(buf_empty, 3'h6);
    arb(32'h000000A1, 4'h3, 64'h1122330000000000);
    sent(3'h7);
    check(buf_aborted, 3'h0);
    $display("test priority done");
    send(32'h000000D1, 4'h8, 8'h03, ok);
    send(32'h000000D2, 4'h8, 8'h09, ok);
    wait_empty(3'h4);
    arb(32'h000000D1, 4'h8, PAY);
    tick(1);
    abort_req = 3'h3;
    tick(1);
    abort_req = 3'h0;
    watch();
    check(irqs, 1);
    check(buf_aborted, 3'h2);
    check(buf_empty, 3'h6);
    check(tx_busy, 1'b1);
    sent(3'h7);
    check(buf_aborted, 3'h2);
    check(buf_empty, 3'h7);
    $display("test abort done");
    acc = 0;
    ok = 1'b1;
    while (ok && acc < 16) begin
      send(32'(acc), 4'h8, 8'h04, ok);
      if (ok) acc++;
    end
    check(acc, 11);
    for (int k = 0; k < 11; k++) begin
      w = 0;
      while (tx_pending !== 1'b1 && w < 100) begin
        tick(1);
        w++;
      end
      pulse(sof);
      check(tx_start, 1'b1);
      sent(3'h7);
      check(irqs, 1);
    end
    wait_empty(3'h7);
    check(buf_aborted, 3'h0);
    check(msg_ready, 1'b1);
    $display("test fill done");
    stamp_en = 1'b1;
    init_mode = 1'b1;
    tick(2);
    init_mode = 1'b0;
    repeat (5) pulse(bit_tick);
    pulse(rx_ack);
    check(rx_stamp, 16'h0005);
    init_mode = 1'b1;
    pulse(bit_tick);
    init_mode = 1'b0;
    pulse(rx_ack);
    check(rx_stamp, 16'h0000);
    $display("test stamp done");
    complete_run();
  end
endmodule
`default_nettype wire
